// *** ufsb_soc.sv ***
// ************************************************************
// Synchronous FIFO, flop storage, count based
// ************************************************************
module ufsb_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 15,
  parameter int unsigned CNT_W = 4
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [CNT_W-1:0]      count
);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [CNT_W-1:0] wr_ptr;
  logic [CNT_W-1:0] rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = (count != FULL);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointers wrap at DEPTH, which need not be a power of two
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      if (pop)  rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      if (push && !pop) count <= count + 1'b1;
      else if (pop && !push) count <= count - 1'b1;
    end
  end

  // Storage needs no reset
  always_ff @(posedge sys_clk) begin
    if (push) mem[wr_ptr] <= in_data;
  end
endmodule // ufsb_fifo

// Contract
// - Board pulses design reset after configuration
// - Bus reset comes from the design reset
// - Bus clock equals the USB interface clock
// - Shared bus with 32-bit data paths
// - Single read or write cycles, never bursts
// - Upper address bits select the slave
// - One cycle per register, several per block
// - Block address auto-increment chosen by host
// - Byte address shifted right two for ADR_O
// - Strobe qualifies master address, data, control
// - Write enable high for write, low read
// - Slave acknowledge confirms write or read data
// - Master waits for late acknowledge
// - Combinational acknowledge in first strobe clock
// - Slower slaves use a registered acknowledge
// - Benchmark register acknowledges with zero delay
// - Fifty GPIO pins, each direction configurable
// - Flash command register supports whole erase
// - Flash controller moves four bytes, erases
// - Interface FIFO holds fifteen entries
// - 16-bit words pair into 32-bit words
// - FIFO strobes active low, synchronous
module ufsb_soc
  import ufsb_pkg::*;
(
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                reset,
  // USB bridge slave FIFO port
  input  wire logic [USB_W-1:0]    usb_data_in,
  output logic      [USB_W-1:0]    usb_data_out,
  output logic                     usb_data_oe,
  input  wire logic                usb_empty_n,
  input  wire logic                usb_almost_full_n,
  output logic                     usb_rd_n,
  output logic                     usb_wr_n,
  output logic                     usb_oe_n,
  output logic                     packet_commit_n,
  output logic      [1:0]          endpoint_select,
  // GPIO pins
  input  wire logic [GPIO_N-1:0]   gpio_in,
  output logic      [GPIO_N-1:0]   gpio_out,
  output logic      [GPIO_N-1:0]   gpio_oe,
  // SPI flash
  output logic                     flash_cs_n,
  output logic                     flash_sck,
  output logic                     flash_mosi,
  input  wire logic                flash_miso
);

  // ************************************************************
  // System controller
  // ************************************************************
  logic bus_rst;

  // The board pulses reset after loading, so one register suffices
  always_ff @(posedge sys_clk) begin
    bus_rst <= reset;
  end

  // ************************************************************
  // Inbound path: USB bridge into the interface FIFO
  // ************************************************************
  ufsb_mst_t             mst;
  logic [USB_W-1:0]      fifo_word;
  logic                  fifo_valid;
  logic                  fifo_pop;
  logic [FIFO_CNT_W-1:0] fifo_count;
  logic                  usb_push;
  logic                  sending;

  assign sending  = (mst == M_SLO) || (mst == M_SHI);
  assign usb_push = !usb_rd_n && usb_empty_n;

  ufsb_fifo #(
    .WIDTH (USB_W),
    .DEPTH (FIFO_DEPTH),
    .CNT_W (FIFO_CNT_W)
  ) u_h2p_fifo (
    .sys_clk   (sys_clk),
    .rst       (bus_rst),
    .in_valid  (usb_push),
    .in_ready  (),
    .in_data   (usb_data_in),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_word),
    .count     (fifo_count)
  );

  // Read strobes alternate with idle cycles so the empty flag is
  // always fresh; a room margin keeps the in-flight word safe
  always_ff @(posedge sys_clk) begin
    if (bus_rst) begin
      usb_rd_n        <= 1'b1;
      usb_oe_n        <= 1'b1;
      endpoint_select <= EP_H2P;
      packet_commit_n <= 1'b1;
    end else begin
      usb_rd_n <= !(usb_rd_n && usb_empty_n && !sending
                    && (fifo_count < FIFO_ROOM_MAX));
      usb_oe_n        <= sending;
      endpoint_select <= sending ? EP_P2H : EP_H2P;
      packet_commit_n <= 1'b1;
    end
  end

  // ************************************************************
  // Bus master
  // ************************************************************
  logic [BUS_W-1:0] adr;
  logic [BUS_W-1:0] dat_o;
  logic [BUS_W-1:0] dat_i;
  logic             stb;
  logic             we;
  logic             ack;
  logic             autoinc;
  logic [USB_W-1:0] cycles_left;
  logic [USB_W-1:0] adr_lo;
  logic [BUS_W-1:0] rd_word;
  logic             can_wr;

  assign fifo_pop = fifo_valid && (mst inside {M_HDR, M_CNT, M_ALO,
                                               M_AHI, M_DLO, M_DHI});
  // Almost full leaves a spare word; the gap cycle keeps flags fresh
  assign can_wr = usb_almost_full_n && usb_wr_n;

  // Header, count, address, then one single cycle per word
  always_ff @(posedge sys_clk) begin
    if (bus_rst) begin
      mst          <= M_HDR;
      stb          <= 1'b0;
      we           <= 1'b0;
      adr          <= '0;
      dat_o        <= '0;
      autoinc      <= 1'b0;
      cycles_left  <= '0;
      adr_lo       <= '0;
      rd_word      <= '0;
      usb_wr_n     <= 1'b1;
      usb_data_oe  <= 1'b0;
      usb_data_out <= '0;
    end else begin
      usb_wr_n    <= 1'b1;
      usb_data_oe <= 1'b0;
      case (mst)
        M_HDR: if (fifo_pop) begin
          we      <= fifo_word[HDR_WRITE_BIT];
          autoinc <= fifo_word[HDR_AUTOINC_BIT];
          mst     <= M_CNT;
        end
        M_CNT: if (fifo_pop) begin
          cycles_left <= fifo_word;
          mst         <= M_ALO;
        end
        M_ALO: if (fifo_pop) begin
          adr_lo <= fifo_word;
          mst    <= M_AHI;
        end
        M_AHI: if (fifo_pop) begin
          adr <= {fifo_word, adr_lo} >> ADR_SHIFT;
          stb <= !we;
          mst <= we ? M_DLO : M_BUS;
        end
        M_DLO: if (fifo_pop) begin
          dat_o[USB_W-1:0] <= fifo_word;
          mst              <= M_DHI;
        end
        M_DHI: if (fifo_pop) begin
          dat_o[BUS_W-1:USB_W] <= fifo_word;
          stb                  <= 1'b1;
          mst                  <= M_BUS;
        end
        M_BUS: if (ack) begin
          stb     <= 1'b0;
          rd_word <= dat_i;
          mst     <= we ? M_NEXT : M_SLO;
        end
        M_SLO: if (can_wr) begin
          usb_wr_n     <= 1'b0;
          usb_data_oe  <= 1'b1;
          usb_data_out <= rd_word[USB_W-1:0];
          mst          <= M_SHI;
        end
        M_SHI: if (can_wr) begin
          usb_wr_n     <= 1'b0;
          usb_data_oe  <= 1'b1;
          usb_data_out <= rd_word[BUS_W-1:USB_W];
          mst          <= M_NEXT;
        end
        M_NEXT: begin
          if (cycles_left == '0) begin
            mst <= M_HDR;
          end else begin
            cycles_left <= cycles_left - 1'b1;
            if (autoinc) adr <= adr + 1'b1;
            stb <= !we;
            mst <= we ? M_DLO : M_BUS;
          end
        end
        default: mst <= M_HDR;
      endcase
    end
  end

  // ************************************************************
  // Shared interconnect
  // ************************************************************
  logic [1:0]       sel;
  logic             bram_ack;
  logic             speed_ack;
  logic             gpio_ack;
  logic             fl_ack;
  logic [BUS_W-1:0] bram_rdat;
  logic [BUS_W-1:0] speed_reg;
  logic [BUS_W-1:0] gpio_rdat;
  logic [BUS_W-1:0] fl_rdat;

  assign sel = adr[SEL_HI:SEL_LO];

  // Every select code is mapped, so no cycle can hang
  always_comb begin
    case (sel)
      SLV_BRAM: begin
        ack   = bram_ack;
        dat_i = bram_rdat;
      end
      SLV_SPEED: begin
        ack   = speed_ack;
        dat_i = speed_reg;
      end
      SLV_GPIO: begin
        ack   = gpio_ack;
        dat_i = gpio_rdat;
      end
      default: begin
        ack   = fl_ack;
        dat_i = fl_rdat;
      end
    endcase
  end

  // ************************************************************
  // Block RAM slave, registered acknowledge
  // ************************************************************
  logic [BUS_W-1:0]   bram [BRAM_WORDS];
  logic [BRAM_AW-1:0] bram_idx;
  logic               bram_go;

  assign bram_idx = adr[BRAM_AW-1:0];
  assign bram_go  = stb && (sel == SLV_BRAM) && !bram_ack;

  always_ff @(posedge sys_clk) begin
    if (bus_rst) begin
      bram_ack  <= 1'b0;
      bram_rdat <= '0;
    end else begin
      bram_ack <= bram_go;
      if (bram_go && !we) bram_rdat <= bram[bram_idx];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (bram_go && we) bram[bram_idx] <= dat_o;
  end

  // ************************************************************
  // Benchmark slave, zero delay acknowledge
  // ************************************************************
  // Combinational path costs timing but gives one-clock transfers
  assign speed_ack = stb && (sel == SLV_SPEED);

  always_ff @(posedge sys_clk) begin
    if (bus_rst) speed_reg <= '0;
    else if (speed_ack && we) speed_reg <= dat_o;
  end

  // ************************************************************
  // GPIO slave, direction bit high drives the pin
  // ************************************************************
  logic gpio_go;

  assign gpio_go = stb && (sel == SLV_GPIO) && !gpio_ack;

  always_ff @(posedge sys_clk) begin
    if (bus_rst) begin
      gpio_ack  <= 1'b0;
      gpio_rdat <= '0;
      gpio_out  <= '0;
      gpio_oe   <= '0;  // Pins come up as inputs
    end else begin
      gpio_ack <= gpio_go;
      if (gpio_go && we) begin
        case (adr[2:0])
          GPIO_OUT_LO: gpio_out[BUS_W-1:0]      <= dat_o;
          GPIO_OUT_HI: gpio_out[GPIO_N-1:BUS_W] <= dat_o[GPIO_HI_W-1:0];
          GPIO_DIR_LO: gpio_oe[BUS_W-1:0]       <= dat_o;
          GPIO_DIR_HI: gpio_oe[GPIO_N-1:BUS_W]  <= dat_o[GPIO_HI_W-1:0];
          default: ;
        endcase
      end
      if (gpio_go && !we) begin
        case (adr[2:0])
          GPIO_OUT_LO: gpio_rdat <= gpio_out[BUS_W-1:0];
          GPIO_OUT_HI: gpio_rdat <= BUS_W'(gpio_out[GPIO_N-1:BUS_W]);
          GPIO_DIR_LO: gpio_rdat <= gpio_oe[BUS_W-1:0];
          GPIO_DIR_HI: gpio_rdat <= BUS_W'(gpio_oe[GPIO_N-1:BUS_W]);
          GPIO_IN_LO:  gpio_rdat <= gpio_in[BUS_W-1:0];
          GPIO_IN_HI:  gpio_rdat <= BUS_W'(gpio_in[GPIO_N-1:BUS_W]);
          default:     gpio_rdat <= '0;
        endcase
      end
    end
  end

  // ************************************************************
  // Flash slave and SPI engine, sck at half the bus clock
  // ************************************************************
  ufsb_fl_t         fl_state;
  logic [63:0]      fl_sh;
  logic [63:0]      fl_main;
  logic [6:0]       fl_len;
  logic [6:0]       fl_cnt;
  logic [BUS_W-1:0] fl_rx;
  logic             fl_phase;
  logic             fl_status;
  logic [23:0]      fl_badr;
  logic             fl_go;
  logic             fl_cmd;

  assign fl_go   = stb && (sel == SLV_FLASH) && !fl_ack
                   && (fl_state == F_IDLE);
  assign fl_cmd  = adr[FLASH_CMD_BIT];
  assign fl_badr = 24'({adr[FLASH_WADR_W-1:0], 2'h0});

  // Program and erase need a write-enable frame first; the host polls
  // the status read for completion, since erase lasts a long time
  always_ff @(posedge sys_clk) begin
    if (bus_rst) begin
      fl_state   <= F_IDLE;
      fl_sh      <= '0;
      fl_main    <= '0;
      fl_len     <= '0;
      fl_cnt     <= '0;
      fl_rx      <= '0;
      fl_phase   <= 1'b0;
      fl_status  <= 1'b0;
      fl_ack     <= 1'b0;
      fl_rdat    <= '0;
      flash_cs_n <= 1'b1;
      flash_sck  <= 1'b0;
      flash_mosi <= 1'b0;
    end else begin
      fl_ack <= 1'b0;
      case (fl_state)
        F_IDLE: if (fl_go) begin
          fl_status <= fl_cmd && !we;
          fl_state  <= F_GAP;
          if (fl_cmd && we) begin
            fl_main  <= {OP_ERASE, 56'h0};
            fl_len   <= LEN_OP;
            fl_state <= (dat_o[7:0] == OP_ERASE) ? F_WREN : F_DONE;
          end else if (fl_cmd) begin
            fl_main <= {OP_RDSR, 56'h0};
            fl_len  <= LEN_STAT;
          end else if (we) begin
            fl_main  <= {OP_PROG, fl_badr, dat_o};
            fl_len   <= LEN_DATA;
            fl_state <= F_WREN;
          end else begin
            fl_main <= {OP_READ, fl_badr, 32'h0};
            fl_len  <= LEN_DATA;
          end
          fl_sh  <= {OP_WREN, 56'h0};
          fl_cnt <= LEN_OP;
        end
        F_GAP: begin
          // Chip select high for a cycle between frames
          fl_sh      <= fl_main;
          fl_cnt     <= fl_len;
          flash_cs_n <= 1'b0;
          flash_mosi <= fl_main[63];
          fl_phase   <= 1'b0;
          fl_state   <= F_MAIN;
        end
        F_WREN, F_MAIN: begin
          flash_cs_n <= 1'b0;
          if (flash_cs_n) begin
            flash_mosi <= fl_sh[63];
          end else if (!fl_phase) begin
            flash_sck <= 1'b1;
            fl_phase  <= 1'b1;
          end else begin
            flash_sck  <= 1'b0;
            fl_phase   <= 1'b0;
            fl_rx      <= {fl_rx[BUS_W-2:0], flash_miso};
            fl_sh      <= fl_sh << 1;
            flash_mosi <= fl_sh[62];
            fl_cnt     <= fl_cnt - 1'b1;
            if (fl_cnt == 7'h1) begin
              flash_cs_n <= 1'b1;
              fl_state   <= (fl_state == F_WREN) ? F_GAP : F_DONE;
            end
          end
        end
        F_DONE: begin
          fl_ack   <= 1'b1;
          fl_rdat  <= fl_status ? BUS_W'(fl_rx[7:0]) : fl_rx;
          fl_state <= F_IDLE;
        end
        default: fl_state <= F_IDLE;
      endcase
    end
  end

endmodule // ufsb_soc

// *** ufsb_pkg.sv ***
package ufsb_pkg;

  // ************************************************************
  // Widths and depths
  // ************************************************************
  localparam int unsigned BUS_W      = 32;
  localparam int unsigned USB_W      = 16;
  localparam int unsigned FIFO_DEPTH = 15;
  localparam int unsigned FIFO_CNT_W = 4;
  localparam int unsigned BRAM_AW    = 6;
  localparam int unsigned BRAM_WORDS = 64;
  localparam int unsigned GPIO_N     = 50;
  localparam int unsigned GPIO_HI_W  = 18;

  // ************************************************************
  // USB bridge FIFO port
  // ************************************************************
  localparam logic [1:0] EP_H2P = 2'h0;  // Host to device endpoint
  localparam logic [1:0] EP_P2H = 2'h2;  // Device to host endpoint
  localparam int unsigned HDR_WRITE_BIT   = 0;
  localparam int unsigned HDR_AUTOINC_BIT = 1;
  localparam logic [FIFO_CNT_W-1:0] FIFO_ROOM_MAX = 4'hd;

  // ************************************************************
  // Address map, word addressed after the byte shift
  // ************************************************************
  localparam int unsigned ADR_SHIFT = 2;
  localparam int unsigned SEL_HI    = 27;
  localparam int unsigned SEL_LO    = 26;
  localparam logic [1:0] SLV_BRAM   = 2'h0;
  localparam logic [1:0] SLV_SPEED  = 2'h1;
  localparam logic [1:0] SLV_GPIO   = 2'h2;
  localparam logic [1:0] SLV_FLASH  = 2'h3;
  localparam logic [2:0] GPIO_OUT_LO = 3'h0;
  localparam logic [2:0] GPIO_OUT_HI = 3'h1;
  localparam logic [2:0] GPIO_DIR_LO = 3'h2;
  localparam logic [2:0] GPIO_DIR_HI = 3'h3;
  localparam logic [2:0] GPIO_IN_LO  = 3'h4;
  localparam logic [2:0] GPIO_IN_HI  = 3'h5;
  localparam int unsigned FLASH_CMD_BIT = 25;
  localparam int unsigned FLASH_WADR_W  = 17;  // 4 Mbit as 32-bit words

  // ************************************************************
  // SPI flash opcodes and frame lengths in bits
  // ************************************************************
  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [7:0] OP_READ  = 8'h03;
  localparam logic [7:0] OP_PROG  = 8'h02;
  localparam logic [7:0] OP_RDSR  = 8'h05;
  localparam logic [7:0] OP_ERASE = 8'hc7;
  localparam logic [6:0] LEN_DATA = 7'h40;
  localparam logic [6:0] LEN_STAT = 7'h10;
  localparam logic [6:0] LEN_OP   = 7'h08;

  // ************************************************************
  // State types
  // ************************************************************
  typedef enum logic [3:0] {
    M_HDR, M_CNT, M_ALO, M_AHI, M_DLO, M_DHI, M_BUS, M_SLO, M_SHI, M_NEXT
  } ufsb_mst_t;

  typedef enum logic [2:0] {
    F_IDLE, F_WREN, F_GAP, F_MAIN, F_DONE
  } ufsb_fl_t;

endpackage

// *** ufsb_soc_assertions.sv ***
module ufsb_soc_checker
  import ufsb_pkg::*;
(
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              reset,
  // USB bridge port
  input wire logic              usb_rd_n,
  input wire logic              usb_wr_n,
  input wire logic              usb_oe_n,
  input wire logic              usb_data_oe,
  input wire logic              usb_empty_n,
  input wire logic              usb_almost_full_n,
  input wire logic              packet_commit_n,
  input wire logic [1:0]        endpoint_select,
  // GPIO and flash
  input wire logic [GPIO_N-1:0] gpio_oe,
  input wire logic              flash_cs_n,
  input wire logic              flash_sck
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  // ********
  // Strobe shapes
  // ********
  // A strobe that drops comes back up on the next edge
  sequence s_one_low(logic s);
    !s ##1 s;
  endsequence

  a_rd_one_cycle: assert property (
    $fell(usb_rd_n) |-> s_one_low(usb_rd_n)) else $error("read strobe long");
  a_wr_one_cycle: assert property (
    $fell(usb_wr_n) |-> s_one_low(usb_wr_n)) else $error("write strobe long");
  a_rd_needs_data: assert property (
    $fell(usb_rd_n) |-> $past(usb_empty_n)) else $error("read while empty");
  a_wr_needs_room: assert property (
    $fell(usb_wr_n) |-> $past(usb_almost_full_n)) else $error("write when full");

  // ********
  // Endpoint and bus direction
  // ********
  a_rd_inbound_ep: assert property (
    !usb_rd_n |-> endpoint_select == EP_H2P && !usb_oe_n)
    else $error("read on wrong endpoint");
  a_wr_outbound_ep: assert property (
    !usb_wr_n |-> endpoint_select == EP_P2H && usb_oe_n && usb_data_oe)
    else $error("write on wrong endpoint");
  a_drive_with_wr: assert property (
    usb_data_oe |-> !usb_wr_n) else $error("data bus driven without strobe");
  a_commit_high: assert property (
    packet_commit_n) else $error("packet commit asserted");
  a_sck_in_frame: assert property (
    flash_sck |-> !flash_cs_n) else $error("flash clock outside frame");

  // Reset is registered once, so idle values show after two edges
  a_reset_idle: assert property (disable iff (1'b0)
    reset [*2] |=> usb_rd_n && usb_wr_n && flash_cs_n && !flash_sck &&
      gpio_oe == '0 && endpoint_select == EP_H2P)
    else $error("outputs not idle in reset");
endmodule // ufsb_soc_checker

bind ufsb_soc ufsb_soc_checker u_chk (
  .sys_clk(sys_clk), .reset(reset), .usb_rd_n(usb_rd_n),
  .usb_wr_n(usb_wr_n), .usb_oe_n(usb_oe_n), .usb_data_oe(usb_data_oe),
  .usb_empty_n(usb_empty_n), .usb_almost_full_n(usb_almost_full_n),
  .packet_commit_n(packet_commit_n), .endpoint_select(endpoint_select),
  .gpio_oe(gpio_oe), .flash_cs_n(flash_cs_n), .flash_sck(flash_sck));

// *** ufsb_bridge_model.sv ***
module ufsb_bridge_model
  import ufsb_pkg::*;
(
  // Clock
  input wire logic        sys_clk,
  // Strobes from the device
  input wire logic        usb_rd_n,
  input wire logic        usb_oe_n,
  input wire logic [1:0]  endpoint_select,
  // Flags and data to the device
  input wire logic        stall,
  output logic            usb_empty_n,
  output logic            usb_almost_full_n,
  output logic [USB_W-1:0] usb_data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [USB_W-1:0] q[$];
  logic [USB_W-1:0] last;

  task automatic put(input logic [USB_W-1:0] w);
    q.push_back(w);
  endtask

  task automatic flush();
    q.delete();
  endtask

  initial begin
    usb_empty_n = 1'b0;
    usb_almost_full_n = 1'b1;
    usb_data_in = '0;
    last = '0;
  end

  // Words leave only on a synchronous strobe to the inbound endpoint
  always @(posedge sys_clk) begin
    if (usb_rd_n === 1'b0 && usb_empty_n && q.size() != 0 &&
        endpoint_select === EP_H2P) begin
      last = q.pop_front();
    end
    #1;
    usb_empty_n = q.size() != 0;
    usb_almost_full_n = !stall;
    // A released bus never shows a stale word, so the device cannot rely on it
    usb_data_in = (!usb_oe_n && q.size() != 0) ? q[0] : ~last;
  end
endmodule // ufsb_bridge_model

// *** ufsb_soc_test.sv ***
module ufsb_soc_test
  import ufsb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic              sys_clk, reset, stall, flash_miso;
  logic [USB_W-1:0]  usb_data_in, usb_data_out;
  logic              usb_empty_n, usb_almost_full_n;
  logic              usb_rd_n, usb_wr_n, usb_oe_n;
  logic [1:0]        endpoint_select;
  logic [GPIO_N-1:0] gpio_in, gpio_out, gpio_oe;
  logic              flash_cs_n, flash_sck;
  logic [15:0]       exp_q[$];
  logic [31:0]       rnd, w0, blk[4];
  int                err_total, total_checks, n, rd_seen;

  ufsb_soc u_ufsb_soc (.sys_clk(sys_clk), .reset(reset),
    .usb_data_in(usb_data_in), .usb_data_out(usb_data_out),
    .usb_data_oe(), .usb_empty_n(usb_empty_n),
    .usb_almost_full_n(usb_almost_full_n), .usb_rd_n(usb_rd_n),
    .usb_wr_n(usb_wr_n), .usb_oe_n(usb_oe_n), .packet_commit_n(),
    .endpoint_select(endpoint_select), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .flash_cs_n(flash_cs_n),
    .flash_sck(flash_sck), .flash_mosi(), .flash_miso(flash_miso));
  ufsb_bridge_model u_bridge (.sys_clk(sys_clk), .usb_rd_n(usb_rd_n),
    .usb_oe_n(usb_oe_n), .endpoint_select(endpoint_select),
    .stall(stall), .usb_empty_n(usb_empty_n),
    .usb_almost_full_n(usb_almost_full_n), .usb_data_in(usb_data_in));

  // ********
  // Helpers
  // ********
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic tick();
    @(posedge sys_clk);
    #2;
  endtask

  // Host command: header, count minus one, byte address halves
  task automatic cmd(input logic wr, ai, input int k, input logic [31:0] a);
    u_bridge.put({14'h0, ai, wr});
    u_bridge.put(16'(k - 1));
    u_bridge.put(a[15:0]);
    u_bridge.put(a[31:16]);
  endtask

  task automatic wd(input logic [31:0] d);
    u_bridge.put(d[15:0]);
    u_bridge.put(d[31:16]);
  endtask

  task automatic ex(input logic [31:0] d);
    exp_q.push_back(d[15:0]);
    exp_q.push_back(d[31:16]);
  endtask

  // Bounded wait for both queues, then room for the last bus cycle
  task automatic settle(input string nm);
    for (int i = 0; i < 800; i++) begin
      if (u_bridge.q.size() == 0 && exp_q.size() == 0) break;
      tick();
    end
    if (u_bridge.q.size() + exp_q.size() != 0) begin
      chk("timeout", 32'(u_bridge.q.size() + exp_q.size()), 0);
      wrap_up();
    end else begin
      repeat (20) tick();
      $display("%s done", nm);
    end
  endtask

  // Free running clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Reply words are compared in order as the bridge takes them;
  // inbound read strobes are counted for the fill check
  always @(posedge sys_clk) begin
    if (!reset && usb_rd_n === 1'b0) rd_seen++;
    if (!reset && usb_wr_n === 1'b0) begin
      if (exp_q.size() == 0) chk("extra reply", 32'(exp_q.size()), 1);
      else chk("reply", {16'h0, usb_data_out}, exp_q.pop_front());
    end
  end

  // ********
  // Main sequence
  // ********
  initial begin
    {reset, stall, flash_miso, gpio_in} = {1'b1, 52'h0};
    {err_total, total_checks, rnd} = {64'h0, 32'h5372};
    repeat (10) @(posedge sys_clk);
    #2 reset = 1'b0;
    repeat (2) tick();
    // Low address bits are dropped by the word shift
    w0 = lfsr(rnd);
    cmd(1, 0, 1, 32'h10); wd(w0);
    cmd(0, 0, 1, 32'h13); ex(w0);
    settle("bram single");
    cmd(1, 1, 4, 32'h40);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd); blk[i] = rnd; wd(rnd);
    end
    cmd(0, 1, 4, 32'h40); for (int i = 0; i < 4; i++) ex(blk[i]);
    cmd(0, 0, 2, 32'h44); ex(blk[1]); ex(blk[1]);
    settle("block");
    cmd(1, 0, 1, 32'h10000000); wd(~w0);
    cmd(0, 0, 1, 32'h10000000); ex(~w0);
    cmd(0, 0, 1, 32'h10); ex(w0);
    settle("speed");
    rnd = lfsr(rnd); gpio_in = {rnd[17:0], ~rnd};
    cmd(1, 1, 4, 32'h20000000); wd(rnd); wd(32'h3ffff);
    wd(~rnd); wd(32'h2aaaa);
    cmd(0, 1, 2, 32'h20000010); ex(~rnd); ex({14'h0, rnd[17:0]});
    settle("gpio");
    chk("gpio_out lo", gpio_out[31:0], rnd);
    chk("gpio_out hi", {14'h0, gpio_out[49:32]}, 32'h3ffff);
    chk("gpio_oe lo", gpio_oe[31:0], ~rnd);
    chk("gpio_oe hi", {14'h0, gpio_oe[49:32]}, 32'h2aaaa);
    // Bridge reports almost full, so the reply must wait
    stall = 1'b1;
    cmd(0, 0, 1, 32'h10); ex(w0);
    repeat (60) tick();
    chk("held replies", 32'(exp_q.size()), 2);
    stall = 1'b0;
    settle("stall");
    // A slow flash read holds the bus, so inbound reads stop at the
    // room margin; flash is only read here, never programmed
    n = rd_seen;
    flash_miso = 1'b1;
    cmd(0, 0, 1, 32'h30000000); ex(32'hffffffff);
    cmd(1, 1, 8, 32'h60);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd); wd(rnd); ex(rnd);
    end
    cmd(0, 1, 8, 32'h60);
    repeat (60) tick();
    chk("fifo fill", 32'(rd_seen - n), 4 + FIFO_ROOM_MAX);
    settle("fifo");
    chk("read strobes", 32'(rd_seen - n), 28);
    chk("flash idle", {31'h0, flash_cs_n}, 1);
    chk("flash clock", {31'h0, flash_sck}, 0);
    // Reset lands in the middle of a block command
    cmd(1, 1, 4, 32'h80); wd(rnd);
    repeat (6) tick();
    reset = 1'b1; u_bridge.flush();
    repeat (3) tick();
    chk("reset strobes", {usb_rd_n, usb_wr_n, endpoint_select}, 32'hc);
    chk("reset gpio_oe", gpio_oe[31:0], 0);
    reset = 1'b0;
    repeat (2) tick();
    cmd(1, 0, 1, 32'h80); wd(w0);
    cmd(0, 0, 1, 32'h80); ex(w0);
    settle("reset");
    wrap_up();
  end
endmodule // ufsb_soc_test
